/* File: pkg/accp_defs.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef ACCP_DEFS_VH
`define ACCP_DEFS_VH

`define ACCP_ADDR_STATUS 8'h00
`define ACCP_ADDR_CONTROL 8'h04
`define ACCP_ADDR_CHARGE 8'h08
`define ACCP_ADDR_HIGH_LIMIT 8'h0c
`define ACCP_ADDR_LOW_LIMIT 8'h10
`define ACCP_ADDR_SCL_EDGES 8'h14

`define ACCP_STAT_DONE_BIT 1
`define ACCP_STAT_LOW_BIT 2
`define ACCP_STAT_HIGH_BIT 3
`define ACCP_STAT_ALERT_BIT 4

`define ACCP_CTRL_MODE_LSB 1
`define ACCP_CTRL_MODE_MSB 2
`define ACCP_CTRL_PRESC_LSB 3
`define ACCP_CTRL_PRESC_MSB 5
`define ACCP_CTRL_ACK_BIT 7

`define ACCP_MODE_OFF 2'h0
`define ACCP_MODE_CHARGE_DONE 2'h1
`define ACCP_MODE_ALERT 2'h2

`define ACCP_RESET_MODE 2'h2
`define ACCP_RESET_PRESC 3'h7
`define ACCP_RESET_CHARGE 16'h7fff
`define ACCP_RESET_LOW_LIMIT 16'h0000
`define ACCP_RESET_HIGH_LIMIT 16'hffff
`define ACCP_FORCED_CHARGE 16'hffff

`define ACCP_CLK_MHZ 250
`define ACCP_CHARGE_DONE_MIN_PULSE_NS 1000
`define ACCP_SCL_MAX_KHZ 400
// Filter accepts a quarter of the least pulse so every legal pulse is caught
`define ACCP_DONE_FILTER_CYCLES ((`ACCP_CHARGE_DONE_MIN_PULSE_NS * `ACCP_CLK_MHZ) / 4000)

`endif

/* File: design/accp_prescaler.v */
// Charge prescaler: divides integrator steps by M and reports wrap events
`default_nettype none
module accp_prescaler
(
  input wire clk_in,
  input wire reset_n_in,
  input wire hold_in,
  input wire [2:0] m_code_in,
  input wire step_up_in,
  input wire step_down_in,
  output reg overflow_out,
  output reg underflow_out
);

  reg [6:0] count;
  wire [6:0] top;

  // M is two to the power of the code, so code 7 gives the default of 128
  assign top = (7'h01 << m_code_in) - 7'h01;

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count <= 7'h00;
      overflow_out <= 1'b0;
      underflow_out <= 1'b0;
    end
    else
    begin
      overflow_out <= 1'b0;
      underflow_out <= 1'b0;
      if (hold_in)
      begin
        count <= 7'h00;
      end
      else if (step_up_in && !step_down_in)
      begin
        if (count >= top)
        begin
          count <= 7'h00;
          overflow_out <= 1'b1; // (RULE11)
        end
        else
        begin
          count <= count + 7'h01;
        end
      end
      else if (step_down_in && !step_up_in)
      begin
        if (count == 7'h00)
        begin
          count <= top;
          underflow_out <= 1'b1; // (RULE11)
        end
        else
        begin
          count <= count - 7'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/accp_top.v */
// Shared alert / charge-done pin logic with charge count, limits and APB registers
`include "accp_defs.vh"
`default_nettype none
// Contract
// (RULE1) Control bits [2:1] pick alert output or charge-done input for the pin.
// (RULE2) After reset the pin is in alert mode, released by the alert response.
// (RULE3) Alert mode pulls the open-drain pin low when a limit is crossed.
// (RULE4) Charge-done input high forces the 16-bit charge count to all ones.
// (RULE5) Counting pauses while charge-done is high, resumes from the forced value.
// (RULE6) The charger holds charge-done high at least one microsecond.
// (RULE7) One count is 0.085 mAh times M over 128; M defaults to 128.
// (RULE8) Serial clock up to 400 kHz is accepted; the host stays at or below it.
// (RULE9) Limit crossings set low or high status flags; pin pulls only in alert mode.
// (RULE10) Reset: charge 7fff, low limit 0000, high limit ffff, alert mode, M 128.
// (RULE11) Prescaler overflow adds one count, underflow takes one away.
// (RULE12) In charge-done mode the pin is never driven, flags still report.
module accp_top
#(
  parameter FILTER_CYCLES = `ACCP_DONE_FILTER_CYCLES
)
(
  input wire clk_in,
  input wire reset_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire step_up_in,
  input wire step_down_in,
  input wire scl_in,
  input wire alert_or_charge_done_pin_in,
  output reg alert_or_charge_done_pin_out,
  output reg alert_or_charge_done_pin_oe_out
);

  reg [1:0] pin_mode;
  reg [2:0] presc_code;
  reg [15:0] accumulated_charge_count;
  reg [15:0] high_limit;
  reg [15:0] low_limit;
  reg flag_low;
  reg flag_high;
  reg flag_done;
  reg alert_pending;
  reg [15:0] scl_edges;
  reg pin_meta;
  reg pin_sync;
  reg scl_meta;
  reg scl_sync;
  reg scl_prev;
  reg [7:0] filter_count;
  reg charge_done_input;
  wire access;
  wire wr;
  wire overflow;
  wire underflow;
  wire charge_done_mode;
  wire alert_mode;
  wire over_high;
  wire under_low;
  wire scl_rise;
  reg [31:0] next_rdata;
  reg next_err;

  assign access = psel_in && penable_in && pready_out;
  assign wr = access && pwrite_in;
  assign charge_done_mode = (pin_mode == `ACCP_MODE_CHARGE_DONE); // (RULE1)
  assign alert_mode = (pin_mode == `ACCP_MODE_ALERT); // (RULE1)
  assign over_high = accumulated_charge_count > high_limit;
  assign under_low = accumulated_charge_count < low_limit;
  assign scl_rise = scl_sync && !scl_prev;

  // Two-flop synchronisers for the pin and the serial clock
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= alert_or_charge_done_pin_in;
      pin_sync <= pin_meta;
      scl_meta <= scl_in;
      scl_sync <= scl_meta; // (RULE8)
      scl_prev <= scl_sync;
    end
  end

  // Counts serial clock rising edges; 4 ns sampling resolves 400 kHz easily
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scl_edges <= 16'h0000;
    end
    else if (scl_rise)
    begin
      scl_edges <= scl_edges + 16'h0001; // (RULE8)
    end
  end

  // Glitch filter shorter than the least legal charge-done pulse
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      filter_count <= 8'h00;
      charge_done_input <= 1'b0;
    end
    else if (!charge_done_mode || !pin_sync)
    begin
      filter_count <= 8'h00;
      charge_done_input <= 1'b0;
    end
    else if (filter_count >= FILTER_CYCLES[7:0] - 8'h01)
    begin
      charge_done_input <= 1'b1; // (RULE6)
    end
    else
    begin
      filter_count <= filter_count + 8'h01;
    end
  end

  accp_prescaler u_prescaler
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .hold_in(charge_done_input),
    .m_code_in(presc_code),
    .step_up_in(step_up_in),
    .step_down_in(step_down_in),
    .overflow_out(overflow),
    .underflow_out(underflow)
  );

  // Control, limits and charge count
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_mode <= `ACCP_RESET_MODE; // (RULE2) (RULE10)
      presc_code <= `ACCP_RESET_PRESC; // (RULE7) (RULE10)
      accumulated_charge_count <= `ACCP_RESET_CHARGE; // (RULE10)
      high_limit <= `ACCP_RESET_HIGH_LIMIT; // (RULE10)
      low_limit <= `ACCP_RESET_LOW_LIMIT; // (RULE10)
    end
    else
    begin
      if (wr && paddr_in == `ACCP_ADDR_CONTROL)
      begin
        pin_mode <= pwdata_in[`ACCP_CTRL_MODE_MSB:`ACCP_CTRL_MODE_LSB]; // (RULE1)
        presc_code <= pwdata_in[`ACCP_CTRL_PRESC_MSB:`ACCP_CTRL_PRESC_LSB]; // (RULE7)
      end
      if (wr && paddr_in == `ACCP_ADDR_HIGH_LIMIT)
      begin
        high_limit <= pwdata_in[15:0];
      end
      if (wr && paddr_in == `ACCP_ADDR_LOW_LIMIT)
      begin
        low_limit <= pwdata_in[15:0];
      end
      if (charge_done_input)
      begin
        accumulated_charge_count <= `ACCP_FORCED_CHARGE; // (RULE4) (RULE5)
      end
      else if (wr && paddr_in == `ACCP_ADDR_CHARGE)
      begin
        accumulated_charge_count <= pwdata_in[15:0];
      end
      else if (overflow)
      begin
        accumulated_charge_count <= accumulated_charge_count + 16'h0001; // (RULE11) (RULE5)
      end
      else if (underflow)
      begin
        accumulated_charge_count <= accumulated_charge_count - 16'h0001; // (RULE11) (RULE5)
      end
    end
  end

  // Sticky status flags: write one clears, a new event in the same cycle wins
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flag_low <= 1'b0;
      flag_high <= 1'b0;
      flag_done <= 1'b0;
      alert_pending <= 1'b0;
    end
    else
    begin
      if (under_low)
      begin
        flag_low <= 1'b1; // (RULE9)
      end
      else if (wr && paddr_in == `ACCP_ADDR_STATUS && pwdata_in[`ACCP_STAT_LOW_BIT])
      begin
        flag_low <= 1'b0;
      end
      if (over_high)
      begin
        flag_high <= 1'b1; // (RULE9)
      end
      else if (wr && paddr_in == `ACCP_ADDR_STATUS && pwdata_in[`ACCP_STAT_HIGH_BIT])
      begin
        flag_high <= 1'b0;
      end
      if (charge_done_input)
      begin
        flag_done <= 1'b1;
      end
      else if (wr && paddr_in == `ACCP_ADDR_STATUS && pwdata_in[`ACCP_STAT_DONE_BIT])
      begin
        flag_done <= 1'b0;
      end
      // Alert holds while a limit is crossed in alert mode, then until the host answers the alert response or leaves alert mode
      if (alert_mode && (over_high || under_low))
      begin
        alert_pending <= 1'b1; // (RULE2) (RULE3)
      end
      else if (!alert_mode || (wr && paddr_in == `ACCP_ADDR_CONTROL
                               && pwdata_in[`ACCP_CTRL_ACK_BIT]))
      begin
        alert_pending <= 1'b0; // (RULE2) (RULE12)
      end
    end
  end

  // Open-drain pin: only ever driven low, and only in alert mode
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe_out <= 1'b0;
    end
    else
    begin
      alert_or_charge_done_pin_out <= 1'b0; // (RULE3)
      alert_or_charge_done_pin_oe_out <= alert_mode && alert_pending; // (RULE3) (RULE9) (RULE12)
    end
  end

  // Read mux and decode
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr_in == `ACCP_ADDR_STATUS)
    begin
      next_rdata[`ACCP_STAT_DONE_BIT] = flag_done;
      next_rdata[`ACCP_STAT_LOW_BIT] = flag_low;
      next_rdata[`ACCP_STAT_HIGH_BIT] = flag_high;
      next_rdata[`ACCP_STAT_ALERT_BIT] = alert_pending;
    end
    else if (paddr_in == `ACCP_ADDR_CONTROL)
    begin
      next_rdata[`ACCP_CTRL_MODE_MSB:`ACCP_CTRL_MODE_LSB] = pin_mode;
      next_rdata[`ACCP_CTRL_PRESC_MSB:`ACCP_CTRL_PRESC_LSB] = presc_code;
    end
    else if (paddr_in == `ACCP_ADDR_CHARGE)
    begin
      next_rdata[15:0] = accumulated_charge_count;
    end
    else if (paddr_in == `ACCP_ADDR_HIGH_LIMIT)
    begin
      next_rdata[15:0] = high_limit;
    end
    else if (paddr_in == `ACCP_ADDR_LOW_LIMIT)
    begin
      next_rdata[15:0] = low_limit;
    end
    else if (paddr_in == `ACCP_ADDR_SCL_EDGES)
    begin
      next_rdata[15:0] = scl_edges;
    end
    else
    begin
      next_err = 1'b1;
    end
  end

  // APB answer: one wait state, pready high in the second access cycle
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else if (psel_in && penable_in && !pready_out)
    begin
      pready_out <= 1'b1;
      pslverr_out <= next_err;
      prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

/* File: test/accp_monitor.sv */
// Checker for the register bus and the shared pin ports
`default_nettype none
module accp_monitor
#(
  parameter FILTER_CYCLES = 2
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic alert_or_charge_done_pin_out,
  input wire logic alert_or_charge_done_pin_oe_out
);
  logic [1:0] mode;
  logic wr_ctrl;
  assign wr_ctrl = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h04;
  // Shadow of the pin mode field, updated when a control write completes
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mode <= 2'h2;
    else if (wr_ctrl)
      mode <= pwdata_in[2:1];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_pin_low; !alert_or_charge_done_pin_out; endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("shared pin data driven high");
  property p_ready_wait; psel_in && !penable_in |-> ##2 pready_out; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("access not answered after one wait state");
  property p_ready_pulse; pready_out |=> !pready_out; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_ready; pslverr_out |-> pready_out; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_data_idle; !pready_out |-> prdata_out == 32'h0; endproperty
  a_data_idle: assert property (p_data_idle)
    else $error("read data outside access");
  property p_oe_mode; mode != 2'h2 && $past(mode) != 2'h2 |-> !alert_or_charge_done_pin_oe_out;
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("pin pulled outside alert mode");
  property p_oe_fall;
    $fell(alert_or_charge_done_pin_oe_out) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("pin released without control write");
  property p_rst; $rose(reset_n_in) |-> !alert_or_charge_done_pin_oe_out && !pready_out; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
endmodule
bind accp_top accp_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) u_mon (.clk_in, .reset_n_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .alert_or_charge_done_pin_out, .alert_or_charge_done_pin_oe_out);
`default_nettype wire

/* File: test/accp_far_end.sv */
// Far-side model: charger on the shared pin and serial clock source
`default_nettype none
module accp_far_end
(
  input wire logic pin_oe_in,
  input wire logic level_in,
  output logic pin_out,
  output logic scl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device pull wins; otherwise the charger level, which is high when released
  assign pin_out = pin_oe_in ? 1'h0 : level_in;
  initial scl_out = 1'h1;
  // Clock runs only inside a burst and idles high
  task automatic scl_burst(input int n);
    // Offset from the sampling clock edges so no level changes on one
    #1;
    repeat (n)
    begin
      #80 scl_out = 1'h0;
      #80 scl_out = 1'h1;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/tb_accp_top.sv */
// Self-checking bench for the shared pin block
`default_nettype none
module tb_accp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'h0, reset_n_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
  logic pwrite_in = 1'h0, step_up_in = 1'h0, step_down_in = 1'h0, charger_level = 1'h1;
  logic [7:0] paddr_in = 8'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic pready_out, pslverr_out, scl_in, pin, oe;
  int failures = 0, n_compared = 0;
  always #2 clk_in = ~clk_in;
  accp_top #(.FILTER_CYCLES(2)) u_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .step_up_in, .step_down_in,
    .scl_in, .alert_or_charge_done_pin_in(pin), .alert_or_charge_done_pin_out(),
    .alert_or_charge_done_pin_oe_out(oe));
  accp_far_end u_far (.pin_oe_in(oe), .level_in(charger_level), .pin_out(pin), .scl_out(scl_in));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'h1 && n < 20);
    if (pready_out !== 1'h1)
    begin
      failures++;
      $display("MISMATCH apb ready expected 1 seen %b", pready_out);
    end
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(s, x, r);
  endtask
  task automatic step(input logic up, input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      step_up_in <= up;
      step_down_in <= !up;
      @(posedge clk_in);
      step_up_in <= 1'h0;
      step_down_in <= 1'h0;
    end
  endtask
  task automatic t_reset;
    rd("status", 8'h00, 32'h0);
    rd("control", 8'h04, 32'h3c);
    rd("charge", 8'h08, 32'h7fff);
    rd("high", 8'h0c, 32'hffff);
    rd("low", 8'h10, 32'h0);
  endtask
  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'h0, 8'h18, 32'h0, r, e);
    chk("unmapped err", 32'h1, e);
  endtask
  task automatic t_scl;
    wr(8'h14, 32'h55);
    u_far.scl_burst(5);
    repeat (4) @(posedge clk_in);
    rd("scl edges", 8'h14, 32'h5);
  endtask
  task automatic t_count;
    wr(8'h04, 32'h4);
    step(1'h1, 3);
    step(1'h0, 1);
    rd("charge m1", 8'h08, 32'h8001);
    wr(8'h04, 32'hc);
    step(1'h1, 2);
    rd("charge m2", 8'h08, 32'h8002);
    wr(8'h04, 32'h3c);
    step(1'h1, 127);
    rd("charge m128 hold", 8'h08, 32'h8002);
    step(1'h1, 1);
    rd("charge m128", 8'h08, 32'h8003);
  endtask
  task automatic t_alert;
    wr(8'h0c, 32'h8000);
    repeat (4) @(posedge clk_in);
    chk("oe set", 32'h1, oe);
    rd("status high", 8'h00, 32'h18);
    wr(8'h04, 32'h84);
    repeat (4) @(posedge clk_in);
    chk("oe kept", 32'h1, oe);
    wr(8'h0c, 32'hffff);
    wr(8'h00, 32'h8);
    wr(8'h04, 32'h84);
    repeat (4) @(posedge clk_in);
    chk("oe cleared", 32'h0, oe);
    rd("status clear", 8'h00, 32'h0);
  endtask
  task automatic t_done;
    charger_level <= 1'h0;
    wr(8'h04, 32'h2);
    wr(8'h0c, 32'h8000);
    @(posedge clk_in);
    charger_level <= 1'h1;
    repeat (20) @(posedge clk_in);
    step(1'h1, 1);
    rd("charge forced", 8'h08, 32'hffff);
    chk("oe done", 32'h0, oe);
    // Input stays high 256 cycles of 4 ns, just past one microsecond
    repeat (230) @(posedge clk_in);
    charger_level <= 1'h0;
    repeat (8) @(posedge clk_in);
    step(1'h1, 1);
    rd("charge resumed", 8'h08, 32'h0);
    rd("status done", 8'h00, 32'ha);
  endtask
  task automatic t_modes;
    wr(8'h10, 32'h10);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h04, m << 1);
      repeat (4) @(posedge clk_in);
      chk("oe mode", m == 2, oe);
    end
  endtask
  task print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'h1;
    t_reset;
    t_unmapped;
    t_scl;
    t_count;
    t_alert;
    t_done;
    t_modes;
    print_verdict;
  end
  initial
  begin
    #200000;
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
